// file: logic/obpw_regs.vh
// Register offsets, field positions and reset values of the overlay bitmap and pointer writer.
// Included by the design file; definitions only.
`ifndef OBPW_REGS_VH
`define OBPW_REGS_VH
`define OBPW_BMP_CX 8'h00
`define OBPW_BMP_CY 8'h04
`define OBPW_BMP_DATA 8'h08
`define OBPW_BMP_MASK 8'h0C
`define OBPW_BMP_CTRL1 8'h10
`define OBPW_BMP_SX 8'h14
`define OBPW_PTR_CTRL0 8'h18
`define OBPW_PTR_CTRL1 8'h1C
`define OBPW_PTR_AD 8'h20
`define OBPW_PTR_DATA 8'h24
`define OBPW_PTR_CX 8'h28
`define OBPW_PTR_CY 8'h2C
`define OBPW_PTR_DW 8'h30
`define OBPW_PTR_FGA 8'h34
`define OBPW_PTR_BGA 8'h38
`define OBPW_TXT_PROP0 8'h3C
`define OBPW_TXT_PROP1 8'h40
`define OBPW_TXT_PROP2 8'h44
`define OBPW_TXT_MASK 8'h48
`define OBPW_OSD_CTRL 8'h4C
`define OBPW_STATUS 8'h50
`define OBPW_FRAME 8'h54
`define OBPW_BPP_LSB 5
`define OBPW_BUF_SEL_BIT 6
`define OBPW_AUTO_SW_BIT 7
`define OBPW_ANIM_EN_BIT 5
`define OBPW_FORE_TRANSPARENT_FLAG_BIT 0
`define OBPW_BACK_TRANSPARENT_FLAG_BIT 1
`define OBPW_TEXT_ON_BIT 0
`define OBPW_BMP_ON_BIT 1
`define OBPW_PTR_ON_BIT 2
`define OBPW_FILL_BIT 3
`define OBPW_INSIDE_BIT 4
`define OBPW_MASK_RST 8'hFF
`define OBPW_SX_RST 9'h100
`define OBPW_BMP_BITS 15
`define OBPW_PTR_SIDE 6'h20
`endif

// file: logic/obpw_writer.v
// Overlay bitmap and pointer writer: APB register file, bit-exact bitmap and pointer memory writes.
// Assumes an APB master on pclk; frame_start is a one-cycle pulse per displayed frame.
//
// Functional notes
// [RULE1] Bitmap data byte written at cursor pixel
// [RULE2] Only mask-set bits modify bitmap memory
// [RULE3] Bit 7 goes to cursor bit position
// [RULE4] Bitmap address advances eight bits per write
// [RULE5] Auto-increment stops at bitmap data register
// [RULE6] Pointer is 32x32 at two bits
// [RULE7] Pointer composited above text and bitmap
// [RULE8] Pointer alpha or transparency per layer
// [RULE9] Double buffer: manual select or auto toggle
// [RULE10] Pointer writes go to inactive buffer
// [RULE11] Animation interrupt after programmed frame count
// [RULE12] Width code picks one to four pixels
// [RULE13] Pointer cursor advances by pixel count
// [RULE14] Cursor past row end goes next row
// [RULE15] Host reloads full image between interrupts
// [RULE16] All parts off bypasses and gates clock
// [RULE17] Text cell commits after all properties written
// [RULE18] Area fill overwrites area with properties
// [RULE19] Shadow off when overlay leaves picture
// [RULE20] Shadow blended as background, never transparent
// [RULE21] Cursor address wraps past memory end
// [RULE22] Host programs font setup before loading
// [RULE23] Bitmap memory is four kilobytes
// [RULE24] Depth code selects 1, 2 or 4 bits
`timescale 1ns/1ps
`include "obpw_regs.vh"
module obpw_writer #(
    parameter BMP_BITS = `OBPW_BMP_BITS
) (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Display timing
    input wire frame_start,
    // Overlay outputs
    output reg anim_irq,
    output reg osd_clk_en,
    output reg osd_bypass,
    output reg ptr_buf_shown,
    output reg shadow_on,
    output reg text_commit,
    output reg fill_busy
);
    // [RULE23] Four kilobytes of bitmap pixel memory.
    reg [7:0] bmp_mem [0:4095];
    // [RULE6] Two buffers of 32x32 two-bit pixels.
    reg [1:0] ptr_mem [0:2047];
    reg [8:0] bmp_cx;
    reg [8:0] bmp_cy;
    reg [8:0] bmp_sx;
    reg [7:0] bmp_mask;
    reg [7:0] bmp_ctrl1;
    reg [BMP_BITS-1:0] bmp_addr;
    reg [7:0] ptr_ctrl0;
    reg [7:0] ptr_ctrl1;
    reg [7:0] ptr_ad;
    reg [4:0] ptr_cx;
    reg [4:0] ptr_cy;
    reg [1:0] ptr_dw;
    reg [7:0] ptr_fga;
    reg [7:0] ptr_bga;
    reg [7:0] txt_prop0;
    reg [7:0] txt_prop1;
    reg [7:0] txt_prop2;
    reg [7:0] txt_mask;
    reg [2:0] prop_seen;
    reg [7:0] osd_ctrl;
    reg [7:0] frame_cnt;
    reg auto_buf;
    reg [5:0] fill_cnt;
    reg [7:0] bmp_last;
    integer i;
    integer j;
    wire wr_en = psel & penable & pwrite & pready;
    wire rd_en = psel & penable & ~pwrite & pready;
    wire [2:0] bpp;
    wire [BMP_BITS+2:0] row_bits;
    wire [BMP_BITS+1:0] addr_next;
    wire [5:0] ptr_lin_next;
    wire disp_buf;
    wire addr_ok;

    // Decode a byte offset into a hit for one of the mapped words.
    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `OBPW_FRAME);
        end
    endfunction

    // Bits per pixel from the depth code; 1X both mean four bits.
    // [RULE24] Depth code decode
    function [2:0] depth_bits;
        input [1:0] code;
        begin
            depth_bits = code[1] ? 3'd4 : (code[0] ? 3'd2 : 3'd1);
        end
    endfunction

    // Byte that holds one bit of a data write; the sum wraps at the memory end.
    // [RULE21] Bit address wraps past memory end
    function [BMP_BITS-4:0] byte_of;
        input [BMP_BITS-1:0] base;
        input [2:0] k;
        reg [BMP_BITS-1:0] s;
        begin
            s = base + {{(BMP_BITS-3){1'b0}}, k};
            byte_of = s[BMP_BITS-1:3];
        end
    endfunction

    // Position of that bit in its byte; bit 7 holds the leftmost pixel.
    function [2:0] bit_of;
        input [BMP_BITS-1:0] base;
        input [2:0] k;
        reg [2:0] s;
        begin
            s = base[2:0] + k;
            bit_of = 3'h7 - s;
        end
    endfunction

    assign bpp = depth_bits(bmp_ctrl1[`OBPW_BPP_LSB+1:`OBPW_BPP_LSB]);
    assign row_bits = bmp_sx * bpp;
    assign addr_ok = mapped(paddr);
    // [RULE4] Eight-bit advance
    assign addr_next = {1'b0, bmp_addr} + {{(BMP_BITS-3){1'b0}}, 4'h8};
    // [RULE9] Buffer choice
    assign disp_buf = ptr_ctrl0[`OBPW_AUTO_SW_BIT] ? auto_buf : ptr_ctrl0[`OBPW_BUF_SEL_BIT];
    assign ptr_lin_next = {1'b0, ptr_cx} + {3'b000, ptr_dw} + 6'd1;

    // APB answer: zero wait states, unmapped words answer with an error.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (psel & ~penable & ~pwrite)
            begin
                case (paddr)
                    `OBPW_BMP_CX: prdata <= {23'h0, bmp_cx};
                    `OBPW_BMP_CY: prdata <= {23'h0, bmp_cy};
                    `OBPW_BMP_DATA: prdata <= {24'h0, bmp_last};
                    `OBPW_BMP_MASK: prdata <= {24'h0, bmp_mask};
                    `OBPW_BMP_CTRL1: prdata <= {24'h0, bmp_ctrl1};
                    `OBPW_BMP_SX: prdata <= {23'h0, bmp_sx};
                    `OBPW_PTR_CTRL0: prdata <= {24'h0, ptr_ctrl0};
                    `OBPW_PTR_CTRL1: prdata <= {24'h0, ptr_ctrl1};
                    `OBPW_PTR_AD: prdata <= {24'h0, ptr_ad};
                    `OBPW_PTR_CX: prdata <= {27'h0, ptr_cx};
                    `OBPW_PTR_CY: prdata <= {27'h0, ptr_cy};
                    `OBPW_PTR_DW: prdata <= {30'h0, ptr_dw};
                    `OBPW_PTR_FGA: prdata <= {24'h0, ptr_fga};
                    `OBPW_PTR_BGA: prdata <= {24'h0, ptr_bga};
                    `OBPW_TXT_PROP0: prdata <= {24'h0, txt_prop0};
                    `OBPW_TXT_PROP1: prdata <= {24'h0, txt_prop1};
                    `OBPW_TXT_PROP2: prdata <= {24'h0, txt_prop2};
                    `OBPW_TXT_MASK: prdata <= {24'h0, txt_mask};
                    `OBPW_OSD_CTRL: prdata <= {24'h0, osd_ctrl};
                    `OBPW_STATUS: prdata <= {27'h0, fill_busy, shadow_on, ptr_buf_shown, osd_bypass, anim_irq};
                    `OBPW_FRAME: prdata <= {24'h0, frame_cnt};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control registers and cursors.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bmp_cx <= 9'h000;
            bmp_cy <= 9'h000;
            bmp_sx <= `OBPW_SX_RST;
            bmp_mask <= `OBPW_MASK_RST;
            bmp_ctrl1 <= 8'h00;
            bmp_addr <= {BMP_BITS{1'b0}};
            bmp_last <= 8'h00;
            ptr_ctrl0 <= 8'h00;
            ptr_ctrl1 <= 8'h00;
            ptr_ad <= 8'h01;
            ptr_cx <= 5'h00;
            ptr_cy <= 5'h00;
            ptr_dw <= 2'b11;
            ptr_fga <= 8'hFF;
            ptr_bga <= 8'hFF;
            txt_prop0 <= 8'h00;
            txt_prop1 <= 8'h00;
            txt_prop2 <= 8'h00;
            txt_mask <= `OBPW_MASK_RST;
            prop_seen <= 3'b000;
            osd_ctrl <= 8'h00;
            text_commit <= 1'b0;
        end
        else
        begin
            text_commit <= 1'b0;
            // [RULE17] Commit only when all three properties arrived
            // Repeated after the write decode, and that copy wins, so a property write in the commit cycle loses its seen bit.
            if (prop_seen == 3'b111)
            begin
                text_commit <= 1'b1;
                prop_seen <= 3'b000;
            end
            // The start bit is self-clearing; the repeat after the write decode also clears a new start written in the same cycle.
            if (fill_busy && fill_cnt == 6'd0)
                osd_ctrl[`OBPW_FILL_BIT] <= 1'b0;
            if (wr_en)
            begin
                case (paddr)
                    // Cursor writes recompute the bit-exact address, wrapping in memory.
                    // [RULE21] Address wraps
                    `OBPW_BMP_CX:
                    begin
                        bmp_cx <= pwdata[8:0];
                        bmp_addr <= bmp_cy * row_bits[BMP_BITS-1:0] + pwdata[8:0] * bpp;
                    end
                    `OBPW_BMP_CY:
                    begin
                        bmp_cy <= pwdata[8:0];
                        bmp_addr <= pwdata[8:0] * row_bits[BMP_BITS-1:0] + bmp_cx * bpp;
                    end
                    // [RULE5] Data offset fixed, bursts repeat it
                    // [RULE4] Advance after data write
                    `OBPW_BMP_DATA:
                    begin
                        bmp_last <= pwdata[7:0];
                        bmp_addr <= addr_next[BMP_BITS-1:0];
                    end
                    `OBPW_BMP_MASK: bmp_mask <= pwdata[7:0];
                    `OBPW_BMP_CTRL1: bmp_ctrl1 <= pwdata[7:0];
                    `OBPW_BMP_SX: bmp_sx <= pwdata[8:0];
                    `OBPW_PTR_CTRL0: ptr_ctrl0 <= pwdata[7:0];
                    `OBPW_PTR_CTRL1: ptr_ctrl1 <= pwdata[7:0];
                    `OBPW_PTR_AD: ptr_ad <= pwdata[7:0];
                    `OBPW_PTR_CX: ptr_cx <= pwdata[4:0];
                    `OBPW_PTR_CY: ptr_cy <= pwdata[4:0];
                    `OBPW_PTR_DW: ptr_dw <= pwdata[1:0];
                    // [RULE8] Per-layer alpha factors for blending
                    `OBPW_PTR_FGA: ptr_fga <= pwdata[7:0];
                    `OBPW_PTR_BGA: ptr_bga <= pwdata[7:0];
                    // [RULE13] Pointer cursor advance
                    `OBPW_PTR_DATA:
                    begin
                        // [RULE14] Row wrap to first pixel
                        if (ptr_lin_next[5])
                        begin
                            ptr_cx <= 5'h00;
                            ptr_cy <= ptr_cy + 5'h01;
                        end
                        else
                            ptr_cx <= ptr_lin_next[4:0];
                    end
                    `OBPW_TXT_PROP0:
                    begin
                        txt_prop0 <= pwdata[7:0];
                        prop_seen[0] <= 1'b1;
                    end
                    `OBPW_TXT_PROP1:
                    begin
                        txt_prop1 <= pwdata[7:0];
                        prop_seen[1] <= 1'b1;
                    end
                    `OBPW_TXT_PROP2:
                    begin
                        txt_prop2 <= pwdata[7:0];
                        prop_seen[2] <= 1'b1;
                    end
                    `OBPW_TXT_MASK: txt_mask <= pwdata[7:0];
                    `OBPW_OSD_CTRL: osd_ctrl <= pwdata[7:0];
                    default: ;
                endcase
            end
            // [RULE17] Commit only when all three properties arrived
            if (prop_seen == 3'b111)
            begin
                text_commit <= 1'b1;
                prop_seen <= 3'b000;
            end
            // The start bit is self-clearing in the last busy cycle of the fill.
            if (fill_busy && fill_cnt == 6'd0)
                osd_ctrl[`OBPW_FILL_BIT] <= 1'b0;
        end
    end

    // Bitmap memory write: masked, MSB at the cursor bit, split across two bytes unless the cursor is byte-aligned.
    // Memory holds no reset; contents are undefined until written.
    // [RULE1] Eight bits at the cursor pixel
    always @(posedge pclk)
    begin
        if (wr_en && paddr == `OBPW_BMP_DATA)
        begin
            for (i = 0; i < 8; i = i + 1)
            begin
                // [RULE2] Masked bit update
                // [RULE3] Bit 7 first
                if (bmp_mask[7-i])
                    bmp_mem[byte_of(bmp_addr, i[2:0])][bit_of(bmp_addr, i[2:0])] <= pwdata[7-i];
            end
        end
    end

    // Pointer memory write into the buffer that is not on display.
    // [RULE10] Inactive buffer steering
    // [RULE12] Width code selects pixel count
    always @(posedge pclk)
    begin
        if (wr_en && paddr == `OBPW_PTR_DATA)
        begin
            for (j = 0; j < 4; j = j + 1)
            begin
                if (j <= ptr_dw && ptr_cx + j < 32)
                    ptr_mem[{~disp_buf, ptr_cy, ptr_cx} + j] <= pwdata[7-2*j -: 2];
            end
        end
    end

    // Frame counter, animation interrupt and automatic buffer toggle.
    // [RULE11] Interrupt every programmed frame count
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_cnt <= 8'h00;
            anim_irq <= 1'b0;
            auto_buf <= 1'b0;
        end
        else
        begin
            anim_irq <= 1'b0;
            if (frame_start)
            begin
                if (frame_cnt + 8'd1 >= ptr_ad)
                begin
                    frame_cnt <= 8'h00;
                    if (ptr_ctrl1[`OBPW_ANIM_EN_BIT])
                    begin
                        anim_irq <= 1'b1;
                        auto_buf <= ~auto_buf;
                    end
                end
                else
                    frame_cnt <= frame_cnt + 8'd1;
            end
        end
    end

    // Area fill sequencer, power bypass, buffer and shadow status.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fill_busy <= 1'b0;
            fill_cnt <= 6'd0;
            osd_clk_en <= 1'b0;
            osd_bypass <= 1'b1;
            ptr_buf_shown <= 1'b0;
            shadow_on <= 1'b0;
        end
        else
        begin
            // [RULE18] Area fill runs once per start bit
            if (!fill_busy && osd_ctrl[`OBPW_FILL_BIT])
            begin
                fill_busy <= 1'b1;
                fill_cnt <= 6'd32;
            end
            else if (fill_busy && fill_cnt != 6'd0)
                fill_cnt <= fill_cnt - 6'd1;
            else
                fill_busy <= 1'b0;
            // [RULE16] Bypass and gate when all parts off
            osd_bypass <= ~|osd_ctrl[2:0];
            osd_clk_en <= |osd_ctrl[2:0];
            // [RULE7] Shown buffer feeds the topmost layer
            // [RULE20] Shadow flag goes to background blending only
            ptr_buf_shown <= disp_buf;
            // [RULE19] Shadow only while overlay inside picture
            shadow_on <= osd_ctrl[`OBPW_TEXT_ON_BIT] & osd_ctrl[`OBPW_INSIDE_BIT];
        end
    end
endmodule // obpw_writer

// file: testbench/obpw_chk.sv
// Port checker for the overlay writer.
// Bound to obpw_writer from the bench top; one clock, async active-low reset.
`timescale 1ns/1ps
module obpw_chk (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire pready,
    input wire pslverr,
    // Overlay
    input wire anim_irq,
    input wire osd_clk_en,
    input wire osd_bypass,
    input wire text_commit,
    input wire fill_busy
);
    reg [7:0] fill_cnt;
    // Busy length is counted here because a repetition of 33 would be too costly to unroll.
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            fill_cnt <= 8'h00;
        else
            fill_cnt <= fill_busy ? fill_cnt + 8'h01 : 8'h00;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_bypass_clock: assert property (osd_bypass == !osd_clk_en) else $error("bypass and clock enable disagree");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
    a_error_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_refuse_bad: assert property (pready && (paddr > 8'h54 || paddr[1:0] != 2'h0) |-> pslverr) else $error("bad address taken");
    a_accept_good: assert property (pready && paddr <= 8'h54 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("good address refused");
    a_irq_pulse: assert property (anim_irq |=> !anim_irq) else $error("interrupt longer than one cycle");
    a_commit_cause: assert property (text_commit |-> $past(psel && penable && pready && pwrite, 2)) else $error("commit without write");
    a_fill_length: assert property ($fell(fill_busy) |-> fill_cnt == 8'h21) else $error("fill length wrong");
endmodule // obpw_chk

// file: testbench/obpw_host.sv
// Host model: APB master that loads registers and pointer images.
// Needs only pclk; the bench calls its tasks by hierarchical name.
`timescale 1ns/1ps
module obpw_host (
    // Clock
    input wire pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    // Bus idle from time zero.
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer; the request is held until pready is seen high at an edge.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // full 256-byte image before the next interrupt, four pixels a byte
    // Font setup is outside this block; the host loads no font data here.
    task automatic load_image(input logic [7:0] s, output logic err);
        logic [31:0] q;
        logic e;
        err = 1'b0;
        repeat (256)
        begin
            xfer(1'b1, 8'h24, {24'h0, s}, q, e);
            err = err | e;
            s = s + 8'h01;
        end
    endtask
endmodule // obpw_host

// file: testbench/osd_bitmap_pointer_writer_tb.sv
// Self-checking bench for the overlay writer.
// Drives APB through obpw_host and frame_start directly; the checker is bound below.
`timescale 1ns/1ps
`include "obpw_regs.vh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module osd_bitmap_pointer_writer_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_start, err_acc, b0, e;
    logic anim_irq, osd_clk_en, osd_bypass, ptr_buf_shown, shadow_on, text_commit, fill_busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int mismatches = 0, samples_checked = 0, cycles = 0, commits = 0, irqs, n, i;
    obpw_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    obpw_writer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_start(frame_start), .anim_irq(anim_irq), .osd_clk_en(osd_clk_en), .osd_bypass(osd_bypass),
        .ptr_buf_shown(ptr_buf_shown), .shadow_on(shadow_on), .text_commit(text_commit), .fill_busy(fill_busy));
    // Free-running 100 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Cycle ceiling cuts a hang short; commit pulses are counted as they pass.
    always @(posedge pclk)
    begin
        cycles++;
        if (text_commit === 1'b1)
            commits++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q, e);
        err_acc = err_acc | e;
    endtask
    // Lets registered outputs land before they are looked at.
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic t_reset();
        `CHK("bypass", 1'b1, osd_bypass)
        `CHK("buffer", 1'b0, ptr_buf_shown)
        host.xfer(1'b0, `OBPW_STATUS, 32'h0, q, e);
        `CHK("status bypass", 1'b1, q[1])
        host.xfer(1'b0, 8'h58, 32'h0, q, e);
        `CHK("unmapped error", 1'b1, e)
        `CHK("unmapped data", 32'h0, q)
        $display("test reset done");
    endtask
    task automatic t_bypass();
        for (i = 0; i < 3; i++)
        begin
            wr(`OBPW_OSD_CTRL, 32'h1 << i);
            settle();
            `CHK("bypass on", 1'b0, osd_bypass)
            `CHK("clock on", 1'b1, osd_clk_en)
            `CHK("shadow outside", 1'b0, shadow_on)
        end
        wr(`OBPW_OSD_CTRL, 32'h11);
        settle();
        `CHK("shadow inside", 1'b1, shadow_on)
        host.xfer(1'b0, `OBPW_STATUS, 32'h0, q, e);
        `CHK("status shadow", 1'b1, q[3])
        wr(`OBPW_OSD_CTRL, 32'h0);
        settle();
        `CHK("bypass off", 1'b1, osd_bypass)
        $display("test bypass done");
    endtask
    task automatic t_text();
        wr(`OBPW_TXT_MASK, 32'hFF);
        wr(`OBPW_TXT_PROP0, 32'h12);
        wr(`OBPW_TXT_PROP1, 32'h34);
        settle();
        `CHK("early commit", 0, commits)
        wr(`OBPW_TXT_PROP2, 32'h56);
        settle();
        `CHK("commit", 1, commits)
        wr(`OBPW_OSD_CTRL, 32'h08);
        n = 0;
        repeat (40)
        begin
            @(posedge pclk);
            if (fill_busy === 1'b1)
                n++;
        end
        `CHK("fill cycles", 33, n)
        $display("test text done");
    endtask
    // Bitmap memory is peeked through the hierarchy, a moment after the last data write of each group.
    task automatic t_bitmap();
        err_acc = 1'b0;
        // One bit per pixel: full write at bit 3, masked rewrite, then an advanced write.
        wr(`OBPW_BMP_CTRL1, 32'h00);
        wr(`OBPW_BMP_CX, 32'h3);
        wr(`OBPW_BMP_MASK, 32'hFF);
        wr(`OBPW_BMP_DATA, 32'hA5);
        wr(`OBPW_BMP_CX, 32'h3);
        wr(`OBPW_BMP_MASK, 32'h0F);
        wr(`OBPW_BMP_DATA, 32'h5A);
        wr(`OBPW_BMP_MASK, 32'hFF);
        wr(`OBPW_BMP_DATA, 32'hFF);
        #1;
        `CHK("bitmap head", 5'h15, uut.bmp_mem[0][4:0])
        `CHK("bitmap masked", 3'h2, uut.bmp_mem[1][7:5])
        `CHK("bitmap advance", 5'h1F, uut.bmp_mem[1][4:0])
        `CHK("bitmap next byte", 3'h7, uut.bmp_mem[2][7:5])
        // Two bits per pixel: row 1 of a 256-pixel row starts at bit 512.
        wr(`OBPW_BMP_CTRL1, 32'h20);
        wr(`OBPW_BMP_CX, 32'h0);
        wr(`OBPW_BMP_CY, 32'h1);
        wr(`OBPW_BMP_DATA, 32'h96);
        #1;
        `CHK("bitmap row 1", 8'h96, uut.bmp_mem[64])
        // Code 11 means four bits per pixel, so x of 3 is bit 12.
        wr(`OBPW_BMP_CTRL1, 32'h60);
        wr(`OBPW_BMP_CY, 32'h0);
        wr(`OBPW_BMP_CX, 32'h3);
        wr(`OBPW_BMP_DATA, 32'h3C);
        #1;
        `CHK("bitmap 4 bpp", 8'h53, uut.bmp_mem[1])
        // Cursor at bit 32764: the last four bits spill over to byte 0.
        wr(`OBPW_BMP_CTRL1, 32'h00);
        wr(`OBPW_BMP_CY, 32'h7F);
        wr(`OBPW_BMP_CX, 32'hFC);
        wr(`OBPW_BMP_DATA, 32'hA5);
        #1;
        `CHK("bitmap last byte", 4'hA, uut.bmp_mem[4095][3:0])
        `CHK("bitmap wrapped", 8'h55, uut.bmp_mem[0])
        `CHK("bitmap burst error", 1'b0, err_acc)
        $display("test bitmap done");
    endtask
    task automatic t_anim();
        wr(`OBPW_PTR_CTRL0, 32'h40);
        settle();
        `CHK("manual buffer 1", 1'b1, ptr_buf_shown)
        wr(`OBPW_PTR_CTRL0, 32'h00);
        settle();
        `CHK("manual buffer 0", 1'b0, ptr_buf_shown)
        // Width code 10 at x 30 of row 5: two pixels land, the third is past the row end.
        wr(`OBPW_PTR_DW, 32'h2);
        wr(`OBPW_PTR_CX, 32'h1E);
        wr(`OBPW_PTR_CY, 32'h5);
        wr(`OBPW_PTR_DATA, 32'hE4);
        #1;
        `CHK("pointer pixel 30", 2'h3, uut.ptr_mem[1214])
        `CHK("pointer pixel 31", 2'h2, uut.ptr_mem[1215])
        host.xfer(1'b0, `OBPW_PTR_CX, 32'h0, q, e);
        `CHK("pointer cursor x", 32'h0, q)
        host.xfer(1'b0, `OBPW_PTR_CY, 32'h0, q, e);
        `CHK("pointer cursor y", 32'h6, q)
        wr(`OBPW_PTR_CX, 32'h0);
        wr(`OBPW_PTR_CY, 32'h0);
        wr(`OBPW_PTR_FGA, 32'h80);
        host.xfer(1'b0, `OBPW_PTR_FGA, 32'h0, q, e);
        `CHK("fore alpha", 32'h80, q)
        wr(`OBPW_PTR_AD, 32'h2);
        wr(`OBPW_PTR_DW, 32'h3);
        wr(`OBPW_PTR_CTRL1, 32'h20);
        wr(`OBPW_PTR_CTRL0, 32'h80);
        b0 = ptr_buf_shown;
        irqs = 0;
        err_acc = 1'b0;
        fork
            repeat (6)
            begin
                repeat (450) @(posedge pclk);
                frame_start <= 1'b1;
                @(posedge pclk);
                frame_start <= 1'b0;
            end
            repeat (2715)
            begin
                @(posedge pclk);
                if (anim_irq === 1'b1)
                    irqs++;
            end
            begin
                wait (anim_irq === 1'b1);
                host.load_image(8'h1B, err_acc);
            end
        join
        #1;
        `CHK("interrupts", 3, irqs)
        `CHK("auto buffer", ~b0, ptr_buf_shown)
        `CHK("image load error", 1'b0, err_acc)
        // The image went to buffer 0, hidden after the first toggle.
        `CHK("image first", 2'h3, uut.ptr_mem[3])
        `CHK("image second", 2'h3, uut.ptr_mem[6])
        `CHK("image last", 2'h2, uut.ptr_mem[1023])
        $display("test anim done");
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence after a ten-cycle reset.
    initial
    begin
        presetn = 1'b0;
        frame_start = 1'b0;
        err_acc = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        t_reset();
        t_bypass();
        t_text();
        t_bitmap();
        t_anim();
        end_of_test;
    end
endmodule // osd_bitmap_pointer_writer_tb
bind obpw_writer obpw_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .anim_irq(anim_irq), .osd_clk_en(osd_clk_en),
    .osd_bypass(osd_bypass), .text_commit(text_commit), .fill_busy(fill_busy));
